// >>> hdl/bsp_pkg.sv
package bsp_pkg;
   localparam int CLK_HZ = 20_000_000;
   localparam int SLOW_HZ = 2_000_000;
   localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;
   localparam int PRE_W = 6;
   localparam int DATA_W = 8;

   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_TXDATA = 8'h08;
   localparam logic [7:0] OFS_RXDATA = 8'h0C;
   localparam logic [7:0] OFS_CLKCTRL = 8'h10;
   localparam logic [7:0] OFS_CLKGEN = 8'h14;

   localparam int CTRL_LSB_BIT = 0;
   localparam int CTRL_BIDIR_BIT = 1;
   localparam int CTRL_SEL_LO = 2;
   localparam int CTRL_SEL_HI = 3;
   localparam int CTRL_AUTO_BIT = 4;
   localparam int STAT_TXE_BIT = 0;
   localparam int STAT_RXF_BIT = 1;
   localparam int STAT_BUSY_BIT = 2;
   localparam int CLK_TPH_BIT = 0;
   localparam int CLK_RPH_BIT = 1;
   localparam int CLK_POL_BIT = 2;
   localparam int CLK_SRC_BIT = 4;

   localparam logic [1:0] SEL_FULL = 2'h0;
   localparam logic [1:0] SEL_HALF = 2'h1;
   localparam logic [1:0] SEL_DUAL = 2'h2;
   localparam logic [PRE_W-1:0] PRELOAD_RST = 6'h02;
   localparam logic [3:0] LAST_EDGE_SINGLE = 4'hF;
   localparam logic [3:0] LAST_EDGE_DUAL = 4'h7;

   typedef struct packed {
      logic lsb;
      logic bidir;
      logic [1:0] sel;
      logic auto_rd;
      logic tph;
      logic rph;
      logic pol;
      logic slow;
      logic [PRE_W-1:0] preload;
   } bsp_cfg_s;

   localparam bsp_cfg_s CFG_RST = '{1'b0, 1'b0, SEL_FULL, 1'b0, 1'b0,
      1'b0, 1'b0, 1'b0, PRELOAD_RST};

   typedef enum logic [2:0] {
      REG_CTRL, REG_STATUS, REG_TX, REG_RX, REG_CLKCTRL, REG_CLKGEN,
      REG_NONE
   } bsp_reg_e;

   function automatic bsp_reg_e reg_decode(input logic [7:0] adr);
      case ({adr[7:2], 2'b00})
         OFS_CTRL: return REG_CTRL;
         OFS_STATUS: return REG_STATUS;
         OFS_TXDATA: return REG_TX;
         OFS_RXDATA: return REG_RX;
         OFS_CLKCTRL: return REG_CLKCTRL;
         OFS_CLKGEN: return REG_CLKGEN;
         default: return REG_NONE;
      endcase
   endfunction

   function automatic logic [2:0] bit_pos(input logic [2:0] idx,
                                          input logic lsb);
      return lsb ? idx : 3'h7 - idx;
   endfunction
endpackage

// >>> hdl/bsp_clkgen.sv
`timescale 1ns/1ps
module bsp_clkgen #(
   parameter int PRE_W = bsp_pkg::PRE_W,
   parameter int SLOW_DIV = bsp_pkg::SLOW_DIV
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic run_in,
   input wire logic slow_in,
   input wire logic [PRE_W-1:0] preload_in,
   output logic tick_out
);
   localparam int PS_W = $clog2(SLOW_DIV);
   localparam logic [PS_W-1:0] PS_LAST = PS_W'(SLOW_DIV - 1);
   logic [PS_W-1:0] ps_cnt;
   logic [PRE_W-1:0] cnt;
   logic [PRE_W-1:0] reload;
   logic slow_tick;
   logic step;

   assign slow_tick = (ps_cnt == PS_LAST);
   // preload zero always runs from the main clock
   assign step = (preload_in == '0) || !slow_in || slow_tick;
   assign reload = (preload_in == '0) ? '0 : preload_in - 1'b1;
   assign tick_out = ce_in && run_in && step && (cnt == '0);

   // free-running so the slow reference keeps a steady rate
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in)
         ps_cnt <= '0;
      else if (ce_in)
         ps_cnt <= slow_tick ? '0 : ps_cnt + 1'b1;
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in)
         cnt <= '0;
      else if (ce_in) begin
         if (!run_in)
            cnt <= reload;
         else if (step)
            cnt <= (cnt == '0) ? reload : cnt - 1'b1;
      end
   end
endmodule

// >>> hdl/bsp_shift.sv
`timescale 1ns/1ps
module bsp_shift (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic load_in,
   input wire logic [7:0] data_in,
   input wire logic lsb_in,
   input wire logic dual_in,
   input wire logic tx_step_in,
   input wire logic rx_step_in,
   input wire logic odd_bit_in,
   input wire logic even_bit_in,
   output logic tx_bit_out,
   output logic [7:0] rx_byte_out
);
   logic [7:0] tx_reg;
   logic [2:0] tx_idx;
   logic [2:0] next_tx_idx;
   logic [2:0] rx_idx;
   logic [2:0] pair_base;

   assign next_tx_idx = tx_idx + 3'h1;
   assign pair_base = lsb_in ? {rx_idx[1:0], 1'b0}
                             : 3'h6 - {rx_idx[1:0], 1'b0};

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         tx_reg <= 8'h00;
         tx_idx <= 3'h0;
         tx_bit_out <= 1'b0;
      end else if (ce_in) begin
         if (load_in) begin
            tx_reg <= data_in;
            tx_idx <= 3'h0;
            tx_bit_out <= data_in[bsp_pkg::bit_pos(3'h0, lsb_in)];
         end else if (tx_step_in && tx_idx != 3'h7) begin
            tx_idx <= next_tx_idx;
            tx_bit_out <= tx_reg[bsp_pkg::bit_pos(next_tx_idx, lsb_in)];
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rx_idx <= 3'h0;
         rx_byte_out <= 8'h00;
      end else if (ce_in) begin
         if (load_in)
            rx_idx <= 3'h0;
         else if (rx_step_in) begin
            rx_idx <= rx_idx + 3'h1;
            if (dual_in) begin
               rx_byte_out[pair_base] <= even_bit_in;
               rx_byte_out[pair_base + 3'h1] <= odd_bit_in;
            end else
               rx_byte_out[bsp_pkg::bit_pos(rx_idx, lsb_in)] <= odd_bit_in;
         end
      end
   end
endmodule

// >>> hdl/bsp_master.sv
`timescale 1ns/1ps
module bsp_master (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   output logic serial_clk_out,
   output logic serial_out_pin_out,
   output logic serial_out_pin_oe_out,
   input wire logic serial_out_pin_in,
   input wire logic serial_in_pin_in,
   output logic tx_empty_irq_source_out,
   output logic rx_full_irq_source_out,
   output logic dma_tx_req_out,
   output logic dma_rx_req_out
);
   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_FINISH} bsp_state_e;

   bsp_pkg::bsp_cfg_s cfg;
   bsp_state_e state;
   logic [7:0] tx_hold;
   logic [7:0] rx_data;
   logic [7:0] rx_byte;
   logic [3:0] edge_cnt;
   logic [3:0] last_edge;
   logic tx_empty;
   logic rx_full;
   logic sclk_phase;
   logic dir;
   logic dual_rx;
   logic tick;
   logic load;
   logic tx_step;
   logic rx_step;
   logic one_pin_bit;
   logic odd_bit;
   logic req;
   logic acc;
   logic wr;
   logic rd;
   logic wr_tx;
   logic rd_rx;
   logic [31:0] rd_mux;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   // register bus: ack one cycle after request, effects at the ack edge
   assign req = wb_cyc_in && wb_stb_in;
   assign acc = req && wb_ack_out && ce_in;
   assign wr = acc && wb_we_in && wb_sel_in[0];
   assign rd = acc && !wb_we_in;
   assign wr_tx = wr && bsp_pkg::reg_decode(wb_adr_in) == bsp_pkg::REG_TX;
   assign rd_rx = rd && bsp_pkg::reg_decode(wb_adr_in) == bsp_pkg::REG_RX;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in)
         wb_ack_out <= 1'b0;
      else if (ce_in)
         wb_ack_out <= req && !wb_ack_out;
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (bsp_pkg::reg_decode(wb_adr_in))
         bsp_pkg::REG_CTRL: begin
            rd_mux[bsp_pkg::CTRL_LSB_BIT] = cfg.lsb;
            rd_mux[bsp_pkg::CTRL_BIDIR_BIT] = cfg.bidir;
            rd_mux[bsp_pkg::CTRL_SEL_HI:bsp_pkg::CTRL_SEL_LO] = cfg.sel;
            rd_mux[bsp_pkg::CTRL_AUTO_BIT] = cfg.auto_rd;
         end
         bsp_pkg::REG_STATUS: begin
            rd_mux[bsp_pkg::STAT_TXE_BIT] = tx_empty;
            rd_mux[bsp_pkg::STAT_RXF_BIT] = rx_full;
            rd_mux[bsp_pkg::STAT_BUSY_BIT] = (state != ST_IDLE);
         end
         bsp_pkg::REG_TX: rd_mux[7:0] = tx_hold;
         bsp_pkg::REG_RX: rd_mux[7:0] = rx_data;
         bsp_pkg::REG_CLKCTRL: begin
            rd_mux[bsp_pkg::CLK_TPH_BIT] = cfg.tph;
            rd_mux[bsp_pkg::CLK_RPH_BIT] = cfg.rph;
            rd_mux[bsp_pkg::CLK_POL_BIT] = cfg.pol;
            rd_mux[bsp_pkg::CLK_SRC_BIT] = cfg.slow;
         end
         bsp_pkg::REG_CLKGEN: rd_mux[bsp_pkg::PRE_W-1:0] = cfg.preload;
         bsp_pkg::REG_NONE: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in)
         wb_dat_out <= 32'h0000_0000;
      else if (ce_in && req && !wb_ack_out && !wb_we_in)
         wb_dat_out <= rd_mux;
   end

   // configuration writes
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in)
         cfg <= bsp_pkg::CFG_RST;
      else if (wr) begin
         unique case (bsp_pkg::reg_decode(wb_adr_in))
            bsp_pkg::REG_CTRL: begin
               cfg.lsb <= wb_dat_in[bsp_pkg::CTRL_LSB_BIT];
               cfg.bidir <= wb_dat_in[bsp_pkg::CTRL_BIDIR_BIT];
               cfg.sel <= wb_dat_in[bsp_pkg::CTRL_SEL_HI:bsp_pkg::CTRL_SEL_LO];
               cfg.auto_rd <= wb_dat_in[bsp_pkg::CTRL_AUTO_BIT];
            end
            bsp_pkg::REG_CLKCTRL: begin
               cfg.tph <= wb_dat_in[bsp_pkg::CLK_TPH_BIT];
               cfg.rph <= wb_dat_in[bsp_pkg::CLK_RPH_BIT];
               cfg.pol <= wb_dat_in[bsp_pkg::CLK_POL_BIT];
               cfg.slow <= wb_dat_in[bsp_pkg::CLK_SRC_BIT];
            end
            bsp_pkg::REG_CLKGEN:
               cfg.preload <= wb_dat_in[bsp_pkg::PRE_W-1:0];
            default: cfg <= cfg;
         endcase
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in)
         tx_hold <= 8'h00;
      else if (wr_tx)
         tx_hold <= wb_dat_in[7:0];
   end

   // held byte moves into the shifter when it is free
   assign load = ce_in && state == ST_IDLE && !tx_empty;

   // load sets the flag and wins over a clear in the same cycle
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in)
         tx_empty <= 1'b1;
      else if (load)
         tx_empty <= 1'b1;
      else if (wr_tx)
         tx_empty <= 1'b0;
      else if (rd_rx && cfg.auto_rd)
         tx_empty <= 1'b0;
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rx_full <= 1'b0;
         rx_data <= 8'h00;
      end else if (ce_in && state == ST_FINISH) begin
         rx_full <= 1'b1;
         rx_data <= rx_byte;
      end else if (rd_rx)
         rx_full <= 1'b0;
   end

   assign tx_empty_irq_source_out = tx_empty;
   assign rx_full_irq_source_out = rx_full;
   assign dma_tx_req_out = tx_empty;
   assign dma_rx_req_out = rx_full;

   // byte sequencer
   assign last_edge = dual_rx ? bsp_pkg::LAST_EDGE_DUAL
                              : bsp_pkg::LAST_EDGE_SINGLE;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in)
         state <= ST_IDLE;
      else if (ce_in) begin
         unique case (state)
            ST_IDLE:
               if (load)
                  state <= ST_SHIFT;
            ST_SHIFT:
               if (tick && edge_cnt == last_edge)
                  state <= ST_FINISH;
            ST_FINISH:
               state <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         edge_cnt <= 4'h0;
         sclk_phase <= 1'b0;
         dual_rx <= 1'b0;
      end else if (load) begin
         edge_cnt <= 4'h0;
         dual_rx <= cfg.sel == bsp_pkg::SEL_DUAL && !cfg.bidir;
      end else if (tick) begin
         edge_cnt <= edge_cnt + 4'h1;
         sclk_phase <= !sclk_phase;
      end
   end

   // even edge counts are leading edges, odd ones trailing
   assign tx_step = tick && (edge_cnt[0] ^ cfg.tph) && edge_cnt != 4'h0;
   assign rx_step = tick && (edge_cnt[0] == cfg.rph);

   // direction follows the enable while idle and freezes while shifting
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in)
         dir <= 1'b0;
      else if (ce_in && state == ST_IDLE)
         dir <= cfg.bidir;
   end

   always_comb begin
      one_pin_bit = serial_in_pin_in;
      if ((cfg.sel == bsp_pkg::SEL_HALF || cfg.sel == bsp_pkg::SEL_DUAL) &&
          !dir)
         one_pin_bit = serial_out_pin_in;
   end
   assign odd_bit = dual_rx ? serial_in_pin_in : one_pin_bit;

   bsp_clkgen #(
      .PRE_W(bsp_pkg::PRE_W),
      .SLOW_DIV(bsp_pkg::SLOW_DIV)
   ) u_clkgen (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .run_in(state == ST_SHIFT),
      .slow_in(cfg.slow),
      .preload_in(cfg.preload),
      .tick_out(tick)
   );

   bsp_shift u_shift (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .load_in(load),
      .data_in(tx_hold),
      .lsb_in(cfg.lsb),
      .dual_in(dual_rx),
      .tx_step_in(tx_step),
      .rx_step_in(rx_step),
      .odd_bit_in(odd_bit),
      .even_bit_in(serial_out_pin_in),
      .tx_bit_out(serial_out_pin_out),
      .rx_byte_out(rx_byte)
   );

   assign serial_clk_out = cfg.pol ^ sclk_phase;
   assign serial_out_pin_oe_out = (cfg.sel == bsp_pkg::SEL_HALF ||
      cfg.sel == bsp_pkg::SEL_DUAL) ? dir : 1'b1;

   property p_no_start_when_empty;
      state == ST_IDLE && tx_empty |=> state != ST_SHIFT;
   endproperty
   a_no_start_when_empty: assert property (p_no_start_when_empty)
      else $error("shifting started without a held byte");

   // a busy shifter keeps the byte held, so the reload is only due when idle
   property p_write_clears_empty;
      wr_tx && tx_empty |=> !tx_empty ##1
         (tx_empty || $past(state) != ST_IDLE || !$past(ce_in));
   endproperty
   a_write_clears_empty: assert property (p_write_clears_empty)
      else $error("transmit write did not clear the empty flag");

   property p_load_starts;
      load |=> state == ST_SHIFT && tx_empty && edge_cnt == 4'h0;
   endproperty
   a_load_starts: assert property (p_load_starts)
      else $error("load did not start shifting or set empty");

   property p_finish_sets_full;
      ce_in && state == ST_FINISH |=> rx_full && rx_data == $past(rx_byte);
   endproperty
   a_finish_sets_full: assert property (p_finish_sets_full)
      else $error("byte end did not latch receive data");

   property p_auto_read;
      rd_rx && cfg.auto_rd && tx_empty && state != ST_FINISH
         |=> !rx_full && !tx_empty;
   endproperty
   a_auto_read: assert property (p_auto_read)
      else $error("auto read did not clear both flags");

   property p_clk_idle;
      state != ST_SHIFT |-> serial_clk_out == cfg.pol;
   endproperty
   a_clk_idle: assert property (p_clk_idle)
      else $error("serial clock not at idle level");

   property p_clk_by_tick;
      state == ST_SHIFT && !tick |=> $stable(sclk_phase);
   endproperty
   a_clk_by_tick: assert property (p_clk_by_tick)
      else $error("serial clock moved without an underflow");

   property p_dir_frozen;
      state != ST_IDLE && $past(state) != ST_IDLE |-> $stable(dir);
   endproperty
   a_dir_frozen: assert property (p_dir_frozen)
      else $error("direction changed while shifting");

   property p_dir_tracks;
      ce_in && state == ST_IDLE |=> dir == $past(cfg.bidir);
   endproperty
   a_dir_tracks: assert property (p_dir_tracks)
      else $error("idle direction does not follow enable");

   property p_full_duplex_drives;
      cfg.sel == bsp_pkg::SEL_FULL |-> serial_out_pin_oe_out;
   endproperty
   a_full_duplex_drives: assert property (p_full_duplex_drives)
      else $error("full duplex left the out pin undriven");

   property p_one_pin_dir;
      cfg.sel == bsp_pkg::SEL_HALF |-> serial_out_pin_oe_out == dir;
   endproperty
   a_one_pin_dir: assert property (p_one_pin_dir)
      else $error("half duplex direction mismatch");

   c_byte_done: cover property (state == ST_FINISH ##1 rx_full);
   c_dual_rx: cover property (load ##1 dual_rx ##[1:200] state == ST_FINISH);
   c_auto_read: cover property (rd_rx && cfg.auto_rd ##[1:4] load);
   c_back_to_back: cover property (state == ST_FINISH ##1 load);
endmodule

// >>> bench/bsp_peer_model.sv
`timescale 1ns/1ps
module bsp_peer_model (
   input wire logic sclk_in,
   input wire logic mosi_in,
   output logic miso_out,
   output logic dout_out,
   output logic [7:0] got_out
);
   logic [7:0] r;
   logic pol, tph, rph, lsb, dual, lead;
   int n;
   initial begin
      miso_out = 1'b0;
      dout_out = 1'b0;
      got_out = 8'h00;
      n = 0;
   end
   // puts the bit (or bit pair in dual reception) of step n on the pins
   task automatic present();
      int p;
      p = n % 4;
      if (dual) begin
         miso_out = r[lsb ? 2 * p + 1 : 7 - 2 * p];
         dout_out = r[lsb ? 2 * p : 6 - 2 * p];
      end else begin
         miso_out = r[lsb ? n % 8 : 7 - n % 8];
         dout_out = miso_out;
      end
   endtask
   task automatic arm(input logic [7:0] rv, input logic po, input logic tp,
                      input logic rp, input logic ls, input logic du);
      r = rv;
      pol = po;
      tph = tp;
      rph = rp;
      lsb = ls;
      dual = du;
      n = 0;
      got_out = 8'h00;
      present();
      if (rph) begin
         // nothing valid before the first edge in this phase
         miso_out = ~miso_out;
         dout_out = ~dout_out;
      end
   endtask
   always @(sclk_in) begin
      lead = (sclk_in !== pol);
      if (lead !== tph) begin
         got_out = lsb ? {mosi_in, got_out[7:1]} : {got_out[6:0], mosi_in};
      end
      // change data on the edge the master does not sample on
      if (lead === rph) begin
         if (rph) begin
            present();
            n++;
         end else begin
            n++;
            present();
         end
      end
   end
endmodule

// >>> bench/byte_serial_peripheral_master_test.sv
`timescale 1ns/1ps
module byte_serial_peripheral_master_test;
   logic clk_in, rst_in, cyc, stb, we, ack, sclk, dout, oe, miso, pdout;
   logic pin, txe, rxf, dtx, drx, pol, tph, rph, lsb, dual, ce;
   logic [7:0] adr, got;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, q;
   int fail_count = 0;
   int n_tests = 0;
   int cycles = 0;
   assign pin = oe ? dout : pdout;
   bsp_master i_dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce),
      .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
      .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
      .wb_ack_out(ack), .serial_clk_out(sclk), .serial_out_pin_out(dout),
      .serial_out_pin_oe_out(oe), .serial_out_pin_in(pin),
      .serial_in_pin_in(miso), .tx_empty_irq_source_out(txe),
      .rx_full_irq_source_out(rxf), .dma_tx_req_out(dtx),
      .dma_rx_req_out(drx));
   bsp_peer_model i_peer (.sclk_in(sclk), .mosi_in(pin), .miso_out(miso),
      .dout_out(pdout), .got_out(got));
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         fail_count++;
         results();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s = 4'hF);
      @(posedge clk_in);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      @(posedge clk_in);
      while (ack !== 1'b1) @(posedge clk_in);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic cfg(input logic [1:0] s, input logic b, input logic au);
      wb(1'b1, bsp_pkg::OFS_CLKCTRL, {29'h0, pol, rph, tph});
      wb(1'b1, bsp_pkg::OFS_CTRL, {27'h0, au, s, b, lsb});
   endtask
   task automatic wait_rx();
      q = 32'h0;
      while (q[1] !== 1'b1) wb(1'b0, bsp_pkg::OFS_STATUS, 32'h0);
   endtask
   task automatic xfer(input logic [7:0] t, input logic [7:0] r);
      i_peer.arm(r, pol, tph, rph, lsb, dual);
      wb(1'b1, bsp_pkg::OFS_TXDATA, {24'h0, t});
      wait_rx();
      wb(1'b0, bsp_pkg::OFS_RXDATA, 32'h0);
   endtask
   task automatic t_reset();
      chk({txe, rxf, dtx, drx, sclk, oe}, 6'b101001);
      wb(1'b0, bsp_pkg::OFS_STATUS, 32'h0);
      chk(q, 32'h1);
      wb(1'b1, bsp_pkg::OFS_CLKGEN, 32'h5, 4'h0);
      wb(1'b0, bsp_pkg::OFS_CLKGEN, 32'h0);
      chk(q, 32'h2);
      wb(1'b0, 8'h20, 32'h0);
      chk(q, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_full();
      i_peer.arm(8'h3C, pol, tph, rph, lsb, dual);
      wb(1'b1, bsp_pkg::OFS_TXDATA, 32'hA5);
      @(posedge clk_in);
      wb(1'b0, bsp_pkg::OFS_STATUS, 32'h0);
      chk(q, 32'h5);
      chk({txe, dtx}, 2'b11);
      wb(1'b1, bsp_pkg::OFS_TXDATA, 32'h5A);
      wb(1'b0, bsp_pkg::OFS_STATUS, 32'h0);
      chk(q, 32'h4);
      wait_rx();
      chk({rxf, drx}, 2'b11);
      wb(1'b0, bsp_pkg::OFS_RXDATA, 32'h0);
      chk(q, 32'h3C);
      wait_rx();
      chk(got, 8'h5A);
      wb(1'b0, bsp_pkg::OFS_RXDATA, 32'h0);
      chk(q, 32'h3C);
      @(posedge clk_in);
      wb(1'b0, bsp_pkg::OFS_STATUS, 32'h0);
      chk(q, 32'h1);
      $display("test full duplex done");
   endtask
   task automatic t_modes();
      for (int m = 0; m < 8; m++) begin
         {pol, rph, tph} = m[2:0];
         lsb = m[0];
         cfg(bsp_pkg::SEL_FULL, 1'b0, 1'b0);
         @(negedge clk_in);
         chk(sclk, pol);
         xfer(8'h31 + m[7:0], 8'hC4 ^ m[7:0]);
         chk(q, {24'h0, 8'hC4 ^ m[7:0]});
         chk(got, 8'h31 + m[7:0]);
      end
      $display("test clock modes done");
   endtask
   task automatic t_half();
      {pol, rph, tph, lsb} = 4'h0;
      cfg(bsp_pkg::SEL_HALF, 1'b1, 1'b0);
      xfer(8'h96, 8'h00);
      chk(got, 8'h96);
      cfg(bsp_pkg::SEL_HALF, 1'b0, 1'b0);
      i_peer.arm(8'h2D, pol, tph, rph, lsb, dual);
      wb(1'b1, bsp_pkg::OFS_TXDATA, 32'hFF);
      @(negedge clk_in);
      chk(oe, 1'b0);
      wb(1'b1, bsp_pkg::OFS_CTRL, {27'h0, 1'b0, bsp_pkg::SEL_HALF, 2'b10});
      @(negedge clk_in);
      chk(oe, 1'b0);
      wait_rx();
      wb(1'b0, bsp_pkg::OFS_RXDATA, 32'h0);
      chk(q, 32'h2D);
      @(negedge clk_in);
      chk(oe, 1'b1);
      $display("test half duplex done");
   endtask
   task automatic t_dual();
      cfg(bsp_pkg::SEL_DUAL, 1'b0, 1'b0);
      dual = 1'b1;
      xfer(8'hFF, 8'h96);
      chk(q, 32'h96);
      dual = 1'b0;
      $display("test dual receive done");
   endtask
   task automatic t_auto();
      cfg(bsp_pkg::SEL_FULL, 1'b0, 1'b1);
      xfer(8'hFF, 8'h5B);
      chk(q, 32'h5B);
      wait_rx();
      chk({rxf, drx}, 2'b11);
      cfg(bsp_pkg::SEL_FULL, 1'b0, 1'b0);
      wb(1'b0, bsp_pkg::OFS_RXDATA, 32'h0);
      chk(q, 32'h5B);
      @(posedge clk_in);
      wb(1'b0, bsp_pkg::OFS_STATUS, 32'h0);
      chk(q, 32'h1);
      $display("test auto read done");
   endtask
   task automatic t_hold();
      logic s;
      i_peer.arm(8'h6E, pol, tph, rph, lsb, dual);
      wb(1'b1, bsp_pkg::OFS_TXDATA, 32'hC3);
      repeat (5) @(posedge clk_in);
      ce <= 1'b0;
      @(negedge clk_in);
      s = sclk;
      // one of two cycles would carry a toggle if the enable were ignored
      repeat (2) begin
         @(negedge clk_in);
         chk(sclk, s);
      end
      @(posedge clk_in);
      ce <= 1'b1;
      wait_rx();
      wb(1'b0, bsp_pkg::OFS_RXDATA, 32'h0);
      chk(q, 32'h6E);
      chk(got, 8'hC3);
      $display("test clock enable done");
   endtask
   task automatic t_midreset();
      wb(1'b1, bsp_pkg::OFS_CTRL, 32'h1F);
      wb(1'b1, bsp_pkg::OFS_CLKCTRL, 32'h17);
      wb(1'b1, bsp_pkg::OFS_CLKGEN, 32'h3);
      wb(1'b1, bsp_pkg::OFS_TXDATA, 32'h77);
      repeat (4) @(posedge clk_in);
      rst_in <= 1'b1;
      @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      t_reset();
      wb(1'b0, bsp_pkg::OFS_CTRL, 32'h0);
      chk(q, 32'h0);
      wb(1'b0, bsp_pkg::OFS_CLKCTRL, 32'h0);
      chk(q, 32'h0);
      $display("test mid-run reset done");
   endtask
   initial begin
      rst_in = 1'b1;
      ce = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'h0;
      wdat = 32'h0;
      {pol, tph, rph, lsb, dual} = 5'h00;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      t_reset();
      t_full();
      t_hold();
      t_modes();
      t_half();
      t_dual();
      t_auto();
      t_midreset();
      results();
   end
endmodule
